// ===== rtl/tea_fsm.sv
// terminal activation/deactivation state machine with power-source detection
`timescale 1ns/100ps

module tea_tmr #(
    parameter int CYC = 1
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic start_in,
    input  wire logic stop_in,
    output logic      exp_out
);
    import tea_pkg::*;

    localparam logic [TMR_W-1:0] LOAD = CYC[TMR_W-1:0];

    logic [TMR_W-1:0] cnt_q;
    logic [TMR_W-1:0] cnt_d;
    logic             run_q;
    logic             run_d;

    // not gated by start/stop: those are computed from this output
    assign exp_out = run_q && (cnt_q == 32'h1);

    always_comb begin
        cnt_d = cnt_q;
        run_d = run_q;
        if (start_in) begin
            cnt_d = LOAD;
            run_d = 1'b1;
        end else if (stop_in || exp_out) begin
            run_d = 1'b0;
        end else if (run_q) begin
            cnt_d = cnt_q - 32'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (ce_in) begin
            cnt_q <= cnt_d;
            run_q <= run_d;
        end
    end
endmodule

module tea_fsm #(
    parameter bit SIG_DETECT     = 1'b1,
    parameter bit PERSIST_EN     = 1'b0,
    parameter int T3_CYCLES      = tea_pkg::T3_CYC,
    parameter int PERSIST_CYCLES = tea_pkg::PERSIST_CYC
) (
    input  wire logic          CLK_SYS_IN,
    input  wire logic          SYS_RST_IN,
    input  wire logic          CE_IN,
    input  wire logic          POWER_OK_IN,
    input  wire logic          PSRC_IN,
    input  wire tea_pkg::tea_rx_s RX_IN,
    input  wire logic          ACT_REQ_IN,
    output tea_pkg::tea_tx_e   TX_INFO_OUT,
    output tea_pkg::tea_ind_s  IND_OUT,
    output tea_pkg::tea_state_e STATE_OUT
);
    import tea_pkg::*;

    // pin synchronisers: bit 0 local power, bit 1 power source
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic [1:0] pin_s3_q;
    logic [1:0] pin_q;
    logic [1:0] pin_d;
    logic [1:0] pin_prev_q;
    logic       pwr_rise;
    logic       pwr_fall;
    logic       src_on;
    logic       src_fall;

    tea_state_e st_q;
    tea_state_e st_d;
    tea_tx_e    tx_q;
    tea_tx_e    tx_d;
    tea_ind_s   ind_q;
    tea_ind_s   ind_d;
    tea_ind_s   ind;
    logic       t3_go;
    logic       t3_halt;
    logic       t3_exp;
    logic       defer;
    logic       hold_stop;
    logic       hold_exp;
    logic       in_f48;
    logic       in_f67;
    logic       in_f78;
    logic       pre_rx;

    // a change counts once the second and third stage agree
    always_comb begin
        pin_d = (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q | pin_s3_q));
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            pin_s1_q   <= PIN_RST;
            pin_s2_q   <= PIN_RST;
            pin_s3_q   <= PIN_RST;
            pin_q      <= PIN_RST;
            pin_prev_q <= PIN_RST;
        end else if (CE_IN) begin
            pin_s1_q   <= {PSRC_IN, POWER_OK_IN};
            pin_s2_q   <= pin_s1_q;
            pin_s3_q   <= pin_s2_q;
            pin_q      <= pin_d;
            pin_prev_q <= pin_q;
        end
    end

    assign pwr_rise = pin_q[0] && !pin_prev_q[0];
    assign pwr_fall = !pin_q[0] && pin_prev_q[0];
    assign src_on   = pin_q[1];
    assign src_fall = !pin_q[1] && pin_prev_q[1];
    assign in_f48   = st_q inside {TEA_F4, TEA_F5, TEA_F6, TEA_F7, TEA_F8};
    assign in_f67   = st_q inside {TEA_F6, TEA_F7};
    assign in_f78   = st_q inside {TEA_F7, TEA_F8};
    assign pre_rx   = pwr_fall || pwr_rise || src_fall || t3_exp;

    tea_tmr #(.CYC(T3_CYCLES)) u_t3 (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (SYS_RST_IN),
        .ce_in    (CE_IN),
        .start_in (t3_go),
        .stop_in  (t3_halt),
        .exp_out  (t3_exp)
    );

    // persistence hold cancelled on F7 re-entry
    assign hold_stop = (st_d == TEA_F7) || ind.ph_di;

    tea_tmr #(.CYC(PERSIST_CYCLES)) u_hold (
        .clk_in   (CLK_SYS_IN),
        .rst_in   (SYS_RST_IN),
        .ce_in    (CE_IN),
        .start_in (defer),
        .stop_in  (hold_stop),
        .exp_out  (hold_exp)
    );

    always_comb begin
        st_d    = st_q;
        ind     = '0;
        t3_go   = 1'b0;
        t3_halt = 1'b0;
        defer   = 1'b0;
        if (pwr_fall) begin
            st_d         = TEA_F1_0;
            t3_halt      = 1'b1;
            ind.mph_ii_d = in_f48 || (st_q == TEA_F3);
            ind.mph_di   = in_f48;
            ind.ph_di    = in_f48;
        end else if (pwr_rise) begin
            if (st_q == TEA_F1_0) begin
                st_d = TEA_F1_1;
            end
        end else begin
            case (st_q)
                TEA_F1_0: begin
                    st_d = TEA_F1_0;
                end
                TEA_F1_1: begin
                    if (src_on) begin
                        // source present, level since it may rise with power
                        st_d = TEA_F2;
                    end else if (SIG_DETECT && RX_IN.info4) begin
                        st_d         = TEA_F7;
                        t3_halt      = 1'b1;
                        ind.mph_ii_c = 1'b1;
                        ind.mph_ai   = 1'b1;
                        ind.ph_ai    = 1'b1;
                    end else if (SIG_DETECT && RX_IN.info2) begin
                        st_d         = TEA_F6;
                        t3_halt      = 1'b1;
                        ind.mph_ii_c = 1'b1;
                    end
                end
                default: begin
                    if (src_fall && !(SIG_DETECT && in_f67)) begin
                        st_d         = TEA_F1_1;
                        t3_halt      = 1'b1;
                        ind.mph_ii_d = (st_q != TEA_F2);
                        ind.mph_di   = in_f48;
                        ind.ph_di    = in_f48;
                    end else if (t3_exp && (st_q inside {TEA_F4, TEA_F5, TEA_F6, TEA_F8})) begin
                        ind.mph_di = 1'b1;
                        ind.ph_di  = 1'b1;
                        // F6 stays, no detour via F3
                        if (st_q != TEA_F6) begin
                            st_d = TEA_F3;
                        end
                    end else if (RX_IN.info0 && (st_q inside {TEA_F2, TEA_F6, TEA_F7, TEA_F8})) begin
                        st_d = TEA_F3;
                        if (st_q == TEA_F2) begin
                            ind.mph_ii_c = 1'b1;
                        end else begin
                            ind.mph_di  = 1'b1;
                            ind.mph_ei2 = (st_q == TEA_F8);
                            defer       = PERSIST_EN && in_f78;
                            ind.ph_di   = !(PERSIST_EN && in_f78);
                        end
                    end else if (RX_IN.info4 && (st_q != TEA_F7)) begin
                        st_d         = TEA_F7;
                        t3_halt      = 1'b1;
                        ind.ph_ai    = 1'b1;
                        ind.mph_ai   = 1'b1;
                        ind.mph_ii_c = (st_q == TEA_F2);
                        ind.mph_ei2  = (st_q inside {TEA_F6, TEA_F8});
                    end else if (RX_IN.info2 && (st_q != TEA_F6)) begin
                        st_d         = TEA_F6;
                        ind.mph_ii_c = (st_q == TEA_F2);
                        ind.mph_ei1  = (st_q == TEA_F7);
                        ind.mph_ei2  = (st_q == TEA_F8);
                    end else if (RX_IN.lost_frame && in_f67) begin
                        st_d        = TEA_F8;
                        ind.mph_ei1 = 1'b1;
                    end else if (RX_IN.any_sig && (st_q == TEA_F4)) begin
                        st_d = TEA_F5;
                    end else if (ACT_REQ_IN && (st_q == TEA_F3)) begin
                        st_d  = TEA_F4;
                        t3_go = 1'b1;
                    end
                end
            endcase
        end
    end

    always_comb begin
        ind_d       = ind;
        ind_d.ph_di = ind.ph_di || (hold_exp && (st_d != TEA_F7));
        case (st_d)
            TEA_F4:          tx_d = TEA_TX_INFO1;
            TEA_F6, TEA_F7:  tx_d = TEA_TX_INFO3;
            default:         tx_d = TEA_TX_INFO0;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            st_q  <= ST_RST;
            tx_q  <= TX_RST;
            ind_q <= '0;
        end else if (CE_IN) begin
            st_q  <= st_d;
            tx_q  <= tx_d;
            ind_q <= ind_d;
        end else begin
            ind_q <= '0;
        end
    end

    assign TX_INFO_OUT = tx_q;
    assign IND_OUT     = ind_q;
    assign STATE_OUT   = st_q;

    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (SYS_RST_IN);

    sequence s_quiet_ce;
        CE_IN && !pre_rx;
    endsequence

    sequence s_f4_expiry;
        CE_IN && t3_exp && !pwr_fall && !pwr_rise && !src_fall && (st_q == TEA_F4);
    endsequence

    tx_map_a: assert property (
        (st_q == TEA_F4) == (TX_INFO_OUT == TEA_TX_INFO1)
        && (in_f67 == (TX_INFO_OUT == TEA_TX_INFO3)))
        else $error("line signal does not match state");

    pwr_loss_a: assert property (CE_IN && pwr_fall && in_f48 |=>
        st_q == TEA_F1_0 && IND_OUT.mph_ii_d && IND_OUT.mph_di && IND_OUT.ph_di)
        else $error("power loss not handled");

    pwr_apply_a: assert property (CE_IN && pwr_rise && st_q == TEA_F1_0 |=>
        st_q == TEA_F1_1 && TX_INFO_OUT == TEA_TX_INFO0)
        else $error("power application did not reach F1.1");

    src_gone_a: assert property (CE_IN && !pwr_fall && !pwr_rise && src_fall
        && (st_q inside {TEA_F3, TEA_F4, TEA_F5, TEA_F8}) |=> st_q == TEA_F1_1 && IND_OUT.mph_ii_d)
        else $error("source loss not handled");

    act_req_a: assert property (s_quiet_ce ##0 (ACT_REQ_IN && st_q == TEA_F3
        && RX_IN == '0) |=> st_q == TEA_F4 && TX_INFO_OUT == TEA_TX_INFO1)
        else $error("activate request not taken");

    t3_exp_a: assert property (s_f4_expiry |=>
        st_q == TEA_F3 && IND_OUT.mph_di && IND_OUT.ph_di)
        else $error("T3 expiry in F4 not handled");

    info0_a: assert property (s_quiet_ce ##0 (RX_IN.info0 && in_f67)
        |=> st_q == TEA_F3 && IND_OUT.mph_di && TX_INFO_OUT == TEA_TX_INFO0)
        else $error("info 0 not acted on in time");

    any_sig_a: assert property (s_quiet_ce ##0 (st_q == TEA_F4 && RX_IN.any_sig
        && !RX_IN.info0 && !RX_IN.info2 && !RX_IN.info4) |=> st_q == TEA_F5)
        else $error("unclassified signal left F4 unchanged");

    info4_a: assert property (s_quiet_ce ##0 (RX_IN.info4 && !RX_IN.info0
        && (st_q inside {TEA_F3, TEA_F4, TEA_F5, TEA_F8})) |=> st_q == TEA_F7
        && IND_OUT.ph_ai && IND_OUT.mph_ai && TX_INFO_OUT == TEA_TX_INFO3)
        else $error("info 4 did not activate");

    lost_fr_a: assert property (s_quiet_ce ##0 (RX_IN == 5'h01 && in_f67)
        |=> st_q == TEA_F8 && IND_OUT.mph_ei1 && TX_INFO_OUT == TEA_TX_INFO0)
        else $error("lost framing not handled");

    one_hot_a: assert property ($onehot(st_q))
        else $error("state register not one-hot");
endmodule

// ===== rtl/tea_pkg.sv
// shared constants and types for the terminal activation machine
package tea_pkg;
    localparam int CLK_HZ        = 40_000_000;
    localparam int CYC_PER_MS    = CLK_HZ / 1000;
    localparam int INFO0_RSP_MS  = 25;
    localparam int INFO0_RSP_CYC = INFO0_RSP_MS * CYC_PER_MS;
    localparam int SIG_ID_MS     = 5;
    localparam int SIG_ID_CYC    = SIG_ID_MS * CYC_PER_MS;
    localparam int PERSIST_MS    = 500;
    localparam int PERSIST_CYC   = PERSIST_MS * CYC_PER_MS;
    localparam int T3_MS         = 1000;
    localparam int T3_CYC        = T3_MS * CYC_PER_MS;
    localparam int F3_MAX_FRAMES = 5;
    localparam int TMR_W         = 32;
    localparam logic [1:0] PIN_RST = 2'h0;

    typedef enum logic [8:0] {
        TEA_F1_0 = 9'h001,
        TEA_F1_1 = 9'h002,
        TEA_F2   = 9'h004,
        TEA_F3   = 9'h008,
        TEA_F4   = 9'h010,
        TEA_F5   = 9'h020,
        TEA_F6   = 9'h040,
        TEA_F7   = 9'h080,
        TEA_F8   = 9'h100
    } tea_state_e;

    localparam tea_state_e ST_RST = TEA_F1_0;

    typedef enum logic [1:0] {
        TEA_TX_INFO0 = 2'h0,
        TEA_TX_INFO1 = 2'h1,
        TEA_TX_INFO3 = 2'h3
    } tea_tx_e;

    localparam tea_tx_e TX_RST = TEA_TX_INFO0;

    typedef struct packed {
        logic info0;
        logic info2;
        logic info4;
        logic any_sig;
        logic lost_frame;
    } tea_rx_s;

    typedef struct packed {
        logic ph_ai;
        logic ph_di;
        logic mph_ai;
        logic mph_di;
        logic mph_ii_c;
        logic mph_ii_d;
        logic mph_ei1;
        logic mph_ei2;
    } tea_ind_s;
endpackage

// ===== tb/tea_nt_model.sv
// network termination stand-in that drives the receiver indications
`timescale 1ns/100ps

module tea_nt_model #(
    parameter int T2_CYC = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [2:0]       cmd_in,
    input  wire logic             auto_in,
    input  wire tea_pkg::tea_tx_e tx_in,
    output tea_pkg::tea_rx_s      rx_out
);
    import tea_pkg::*;
    int t2_q;

    always_ff @(posedge clk_in) begin
        if (rst_in || !auto_in || tx_in !== TEA_TX_INFO1) begin
            t2_q <= 0;
        end else if (t2_q < T2_CYC) begin
            t2_q <= t2_q + 1;
        end
    end

    always_ff @(posedge clk_in) begin
        rx_out.info0      <= !rst_in && cmd_in == 3'h1;
        rx_out.info2      <= !rst_in && cmd_in == 3'h2;
        rx_out.info4      <= !rst_in && cmd_in == 3'h3;
        rx_out.any_sig    <= !rst_in && (cmd_in == 3'h4 || t2_q == T2_CYC);
        rx_out.lost_frame <= !rst_in && cmd_in == 3'h5;
    end
endmodule

// ===== tb/test_tea_fsm.sv
// self-checking bench for the terminal activation machine
`timescale 1ns/100ps

module test_tea_fsm;
    import tea_pkg::*;
    localparam int T3_SIM = 20;
    localparam int PERSIST_SIM = 10;
    logic       clk;
    logic       rst;
    logic       pwr;
    logic       psrc;
    logic       act;
    logic       auto_q;
    logic [2:0] cmd;
    tea_rx_s    rx;
    tea_tx_e    tx;
    tea_ind_s   ind;
    tea_ind_s   ind_p;
    tea_state_e st;
    int         fail_count;
    int         checks;
    int         last_n;

    tea_nt_model i_tea_nt_model (.clk_in(clk), .rst_in(rst), .cmd_in(cmd), .auto_in(auto_q),
                                 .tx_in(tx), .rx_out(rx));

    tea_fsm #(.SIG_DETECT(1'b1), .PERSIST_EN(1'b0), .T3_CYCLES(T3_SIM), .PERSIST_CYCLES(PERSIST_SIM)) i_tea_fsm (
        .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1), .POWER_OK_IN(pwr), .PSRC_IN(psrc),
        .RX_IN(rx), .ACT_REQ_IN(act), .TX_INFO_OUT(tx), .IND_OUT(ind), .STATE_OUT(st));

    // same stimulus, persistence hold enabled
    tea_fsm #(.SIG_DETECT(1'b1), .PERSIST_EN(1'b1), .T3_CYCLES(T3_SIM),
              .PERSIST_CYCLES(PERSIST_SIM)) i_tea_fsm_hold (
        .CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1), .POWER_OK_IN(pwr), .PSRC_IN(psrc),
        .RX_IN(rx), .ACT_REQ_IN(act), .TX_INFO_OUT(), .IND_OUT(ind_p), .STATE_OUT());

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic compare(input logic [8:0] got, input logic [8:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] tx_for(input tea_state_e s);
        if (s == TEA_F4) begin
            return TEA_TX_INFO1;
        end
        if (s == TEA_F6 || s == TEA_F7) begin
            return TEA_TX_INFO3;
        end
        return TEA_TX_INFO0;
    endfunction

    // waits for a state, then checks pulses and line signal in that cycle
    task automatic expect_state(input tea_state_e exp, input logic [7:0] ei, input int bound);
        int n;
        n = 0;
        #1;
        while (st !== exp && n < bound) begin
            @(posedge clk);
            #1;
            n++;
        end
        last_n = n;
        if (n >= bound) begin
            fail_count++;
            $display("unexpected timeout at %0t got %h exp %h", $time, st, exp);
            report_and_stop();
        end
        compare({1'b0, ind}, {1'b0, ei});
        compare({7'h00, tx}, {7'h00, tx_for(exp)});
    endtask

    task automatic send(input logic [2:0] c, input tea_state_e exp, input logic [7:0] ei);
        @(posedge clk);
        cmd <= c;
        expect_state(exp, ei, 6);
        @(posedge clk);
        cmd <= 3'h0;
        repeat (3) @(posedge clk);
    endtask

    task automatic pulse_act();
        @(posedge clk);
        act <= 1'b1;
        @(posedge clk);
        act <= 1'b0;
    endtask

    task automatic t_power_up();
        expect_state(TEA_F1_1, 8'h00, 10);
        expect_state(TEA_F2, 8'h00, 10);
        send(3'h1, TEA_F3, 8'h08);
        $display("power up done");
    endtask

    task automatic t_activate();
        auto_q <= 1'b1;
        pulse_act();
        expect_state(TEA_F4, 8'h00, 5);
        expect_state(TEA_F5, 8'h00, 12);
        auto_q <= 1'b0;
        send(3'h3, TEA_F7, 8'ha0);
        $display("activate done");
    endtask

    task automatic t_framing();
        send(3'h5, TEA_F8, 8'h02);
        send(3'h2, TEA_F6, 8'h01);
        send(3'h1, TEA_F3, 8'h50);
        $display("framing done");
    endtask

    task automatic t_expiry();
        pulse_act();
        expect_state(TEA_F4, 8'h00, 5);
        expect_state(TEA_F3, 8'h50, 60);
        compare(9'((last_n >= T3_SIM - 2) && (last_n <= T3_SIM + 2)), 9'h001);
        $display("expiry done");
    endtask

    task automatic t_persist();
        int n;
        send(3'h3, TEA_F7, 8'ha0);
        @(posedge clk);
        cmd <= 3'h1;
        expect_state(TEA_F3, 8'h50, 6);
        compare({1'b0, ind_p}, 9'h010);
        n = 0;
        while (!ind_p.ph_di && n < 3 * PERSIST_SIM) begin
            @(posedge clk);
            #1;
            n++;
        end
        compare(9'(n), 9'(PERSIST_SIM));
        @(posedge clk);
        cmd <= 3'h0;
        repeat (3) @(posedge clk);
        $display("persist done");
    endtask

    task automatic t_supply();
        @(posedge clk);
        psrc <= 1'b0;
        expect_state(TEA_F1_1, 8'h04, 10);
        send(3'h2, TEA_F6, 8'h08);
        @(posedge clk);
        psrc <= 1'b1;
        repeat (6) @(posedge clk);
        psrc <= 1'b0;
        repeat (10) @(posedge clk);
        #1;
        compare(9'(st), 9'(TEA_F6));
        @(posedge clk);
        pwr <= 1'b0;
        expect_state(TEA_F1_0, 8'h54, 10);
        $display("supply done");
    endtask

    initial begin
        rst = 1'b1;
        pwr = 1'b0;
        psrc = 1'b0;
        act = 1'b0;
        auto_q = 1'b0;
        cmd = 3'h0;
        fail_count = 0;
        checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        pwr <= 1'b1;
        psrc <= 1'b1;
        t_power_up();
        t_activate();
        t_framing();
        t_expiry();
        t_persist();
        t_supply();
        report_and_stop();
    end
endmodule
